// ==== hdl/regmap_table_pkg.sv ====
// Purpose: constants for the register-map discovery table section
// Assumes: byte addressing, three doublewords, little-endian byte order
// Notes:   field positions and codes of the capability doubleword
// Behaviour
// - volatile register base reads 00800000h
// - non-volatile register base reads zero
// - capability bit 31: generic read supported
// - capability bit 30: generic write supported
// - bits 29:28 report three address bytes
// - bits 27:26 report single-line dummy bytes
// - bits 13:10 report octal SDR three cycles
// - bits 9:6 report octal DDR three cycles
// - bits 3:0 read 0000b
// - bits 25:14 read all ones
// - reserved bits 5:4 read zero
package regmap_table_pkg;

    // addressing
    localparam int          ADDR_W          = 24;
    localparam logic [23:0] TABLE_BASE      = 24'h00016C;
    localparam int          DW_BYTES        = 4;
    localparam int          DW_COUNT        = 3;
    localparam int          TABLE_BYTES     = DW_BYTES * DW_COUNT;
    localparam int          IDX_W           = 4;
    localparam logic [7:0]  MISS_BYTE       = 8'h00;

    // doubleword indices
    localparam int          DW_VOL          = 0;
    localparam int          DW_NVOL         = 1;
    localparam int          DW_CAPS         = 2;

    // base offsets
    localparam logic [31:0] VOL_OFFSET      = 32'h0080_0000;
    localparam logic [31:0] NVOL_OFFSET     = 32'h0000_0000;

    // capability field positions
    localparam int          GEN_RD_POS      = 31;
    localparam int          GEN_WR_POS      = 30;
    localparam int          ADDR_BYTES_LSB  = 28;
    localparam int          DUMMY_1B_LSB    = 26;
    localparam int          UNSUP_LSB       = 14;
    localparam int          DUMMY_8S_LSB    = 10;
    localparam int          DUMMY_8D_LSB    = 6;
    localparam int          RSVD_LSB        = 4;
    localparam int          DUMMY_1S_LSB    = 0;

    // capability field values
    localparam logic        GEN_RD_SUP      = 1'b1;
    localparam logic        GEN_WR_SUP      = 1'b1;
    localparam logic [1:0]  ADDR_BYTES_CODE = 2'h2;
    localparam logic [1:0]  DUMMY_1B_CODE   = 2'h2;
    localparam logic [11:0] UNSUP_FILL      = 12'hFFF;
    localparam int          OCT_SDR_DUMMY   = 3;
    localparam int          OCT_DDR_DUMMY   = 3;
    localparam logic [3:0]  DUMMY_8S_CODE   = 4'(OCT_SDR_DUMMY);
    localparam logic [3:0]  DUMMY_8D_CODE   = 4'(OCT_DDR_DUMMY);
    localparam logic [1:0]  RSVD_FILL       = 2'h0;
    localparam logic [3:0]  DUMMY_1S_CODE   = 4'h0;

endpackage

// ==== hdl/table_lookup_if.sv ====
// Purpose: carries a table byte lookup between stream control and table
// Assumes: combinational lookup, same clock
// Notes:   hit is low outside the table section
`timescale 1ns/1ps
interface table_lookup_if;
    import regmap_table_pkg::*;

    logic [ADDR_W-1:0] addr;
    logic [7:0]        byte_data;
    logic              hit;

    modport requester (output addr, input byte_data, input hit);
    modport table_end (input addr, output byte_data, output hit);
endinterface

// ==== hdl/regmap_table_rom.sv ====
// Purpose: constant byte table of the register-map doublewords
// Assumes: address is a table byte address
// Notes:   purely combinational
`timescale 1ns/1ps
module regmap_table_rom
    import regmap_table_pkg::*;
(
    // lookup
    table_lookup_if.table_end lk
);

    logic [31:0]       caps_dword;
    logic [31:0]       dwords [DW_COUNT];
    logic [7:0]        table_bytes [TABLE_BYTES];
    logic [ADDR_W-1:0] offset;
    logic              in_range;

    always_comb
    begin
        caps_dword                                 = '0;
        caps_dword[GEN_RD_POS]                     = GEN_RD_SUP;
        caps_dword[GEN_WR_POS]                     = GEN_WR_SUP;
        caps_dword[ADDR_BYTES_LSB +: 2]            = ADDR_BYTES_CODE;
        caps_dword[DUMMY_1B_LSB +: 2]              = DUMMY_1B_CODE;
        caps_dword[UNSUP_LSB +: 12]                = UNSUP_FILL;
        caps_dword[DUMMY_8S_LSB +: 4]              = DUMMY_8S_CODE;
        caps_dword[DUMMY_8D_LSB +: 4]              = DUMMY_8D_CODE;
        caps_dword[RSVD_LSB +: 2]                  = RSVD_FILL;
        caps_dword[DUMMY_1S_LSB +: 4]              = DUMMY_1S_CODE;
    end

    assign dwords[DW_VOL]  = VOL_OFFSET;
    assign dwords[DW_NVOL] = NVOL_OFFSET;
    assign dwords[DW_CAPS] = caps_dword;

    // low byte at the lowest address
    genvar i;
    generate
        for (i = 0; i < TABLE_BYTES; i++)
        begin : g_byte
            assign table_bytes[i] = dwords[i / DW_BYTES][8 * (i % DW_BYTES) +: 8];
        end
    endgenerate

    assign offset       = lk.addr - TABLE_BASE;
    assign in_range     = (lk.addr >= TABLE_BASE) && (offset < ADDR_W'(TABLE_BYTES));
    assign lk.hit       = in_range;
    assign lk.byte_data = in_range ? table_bytes[offset[IDX_W-1:0]] : MISS_BYTE;

endmodule // regmap_table_rom

// ==== hdl/regmap_table_reader.sv ====
// Purpose: streams register-map table bytes from a start address
// Assumes: all inputs come from host-side logic on clock_i
// Notes:   one byte per accepted pull, address ascends by one
`timescale 1ns/1ps
module regmap_table_reader
    import regmap_table_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    // read session
    input  wire logic              start_i,
    input  wire logic [ADDR_W-1:0] start_addr_i,
    input  wire logic              stop_i,
    input  wire logic              pull_i,
    output logic                   pull_ready_o,
    // returned byte
    output logic                   byte_valid_o,
    output logic [7:0]             byte_data_o,
    output logic                   byte_hit_o,
    output logic [ADDR_W-1:0]      byte_addr_o
);

    typedef enum logic [0:0] {ST_IDLE, ST_STREAM} stream_e;

    stream_e           state;
    stream_e           next_state;
    logic [ADDR_W-1:0] pointer;
    logic [ADDR_W-1:0] next_pointer;
    logic              take_pull;
    logic              in_stream;

    table_lookup_if lk ();

    regmap_table_rom u_rom (
        .lk (lk.table_end)
    );

    // decode and selection
    assign in_stream    = (state == ST_STREAM);
    assign take_pull    = in_stream && pull_i && !start_i && !stop_i;
    assign pull_ready_o = in_stream && !start_i && !stop_i;
    assign lk.addr      = pointer;

    always_comb
    begin
        next_state   = state;
        next_pointer = pointer;
        case (state)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    next_state   = ST_STREAM;
                    next_pointer = start_addr_i;
                end
            end
            ST_STREAM:
            begin
                if (start_i)
                begin
                    next_pointer = start_addr_i;
                end
                else if (stop_i)
                begin
                    next_state = ST_IDLE;
                end
                else if (pull_i)
                begin
                    next_pointer = pointer + ADDR_W'(1);
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state   <= ST_IDLE;
            pointer <= '0;
        end
        else
        begin
            state   <= next_state;
            pointer <= next_pointer;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            byte_valid_o <= 1'b0;
            byte_data_o  <= '0;
            byte_hit_o   <= 1'b0;
            byte_addr_o  <= '0;
        end
        else
        begin
            byte_valid_o <= take_pull;
            if (take_pull)
            begin
                byte_data_o <= lk.byte_data;
                byte_hit_o  <= lk.hit;
                byte_addr_o <= pointer;
            end
        end
    end

    // checks
    localparam logic [ADDR_W-1:0] VOL_B2  = TABLE_BASE + ADDR_W'(2);
    localparam logic [ADDR_W-1:0] NVOL_B0 = TABLE_BASE + ADDR_W'(DW_BYTES);
    localparam logic [ADDR_W-1:0] CAPS_B0 = TABLE_BASE + ADDR_W'(2 * DW_BYTES);
    localparam logic [ADDR_W-1:0] CAPS_B1 = CAPS_B0 + ADDR_W'(1);
    localparam logic [ADDR_W-1:0] CAPS_B2 = CAPS_B0 + ADDR_W'(2);
    localparam logic [ADDR_W-1:0] CAPS_B3 = CAPS_B0 + ADDR_W'(3);

    logic             in_vol;
    logic             in_nvol;
    logic             in_table;
    logic             run_full;
    logic [IDX_W-1:0] run_len;
    logic [31:0]      ref_dw [DW_COUNT];

    assign in_vol   = (byte_addr_o >= TABLE_BASE) && (byte_addr_o < NVOL_B0);
    assign in_nvol  = (byte_addr_o >= NVOL_B0) && (byte_addr_o < CAPS_B0);
    assign in_table = (byte_addr_o >= TABLE_BASE) && (byte_addr_o <= CAPS_B3);
    assign run_full = (run_len == IDX_W'(TABLE_BYTES));

    // section words rebuilt from the field constants
    assign ref_dw[DW_VOL]  = VOL_OFFSET;
    assign ref_dw[DW_NVOL] = NVOL_OFFSET;
    assign ref_dw[DW_CAPS] = {GEN_RD_SUP, GEN_WR_SUP, ADDR_BYTES_CODE, DUMMY_1B_CODE, UNSUP_FILL,
                              DUMMY_8S_CODE, DUMMY_8D_CODE, RSVD_FILL, DUMMY_1S_CODE};

    // run of back-to-back bytes from the section start
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || !byte_valid_o)
        begin
            run_len <= '0;
        end
        else if (byte_addr_o == TABLE_BASE)
        begin
            run_len <= IDX_W'(1);
        end
        else if ((run_len != '0) && !run_full)
        begin
            run_len <= run_len + IDX_W'(1);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_vol_base_bytes: assert property (
        byte_valid_o && in_vol |->
            byte_data_o == VOL_OFFSET[8 * (byte_addr_o - TABLE_BASE) +: 8])
        else $error("volatile base byte wrong");

    a_nvol_base_zero: assert property (
        byte_valid_o && in_nvol |-> byte_data_o == NVOL_OFFSET[7:0] && byte_hit_o)
        else $error("non-volatile base byte not zero");

    a_gen_read_bit: assert property (
        byte_valid_o && byte_addr_o == CAPS_B3 |-> byte_data_o[GEN_RD_POS - 24] == GEN_RD_SUP)
        else $error("generic read capability bit wrong");

    a_gen_write_bit: assert property (
        byte_valid_o && byte_addr_o == CAPS_B3 |-> byte_data_o[GEN_WR_POS - 24] == GEN_WR_SUP)
        else $error("generic write capability bit wrong");

    a_addr_bytes_code: assert property (
        byte_valid_o && byte_addr_o == CAPS_B3 |->
            byte_data_o[ADDR_BYTES_LSB - 24 +: 2] == ADDR_BYTES_CODE)
        else $error("address byte code wrong");

    a_single_dummy_bytes: assert property (
        byte_valid_o && byte_addr_o == CAPS_B3 |->
            byte_data_o[DUMMY_1B_LSB - 24 +: 2] == DUMMY_1B_CODE)
        else $error("single-line dummy byte code wrong");

    a_octal_sdr_dummy: assert property (
        byte_valid_o && byte_addr_o == CAPS_B1 |->
            byte_data_o[DUMMY_8S_LSB - 8 +: 4] == DUMMY_8S_CODE)
        else $error("octal SDR dummy code wrong");

    a_octal_ddr_dummy: assert property (
        byte_valid_o && byte_addr_o == CAPS_B0 ##1 byte_valid_o && byte_addr_o == CAPS_B1 |->
            {byte_data_o[1:0], $past(byte_data_o[7:6])} == DUMMY_8D_CODE)
        else $error("octal DDR dummy code wrong");

    a_single_dummy_cyc: assert property (
        byte_valid_o && byte_addr_o == CAPS_B0 |-> byte_data_o[DUMMY_1S_LSB +: 4] == DUMMY_1S_CODE)
        else $error("single-line dummy cycle code wrong");

    a_unsupported_ones: assert property (
        byte_valid_o && byte_addr_o == CAPS_B2 |->
            byte_data_o == UNSUP_FILL[9:2])
        else $error("unsupported field not all ones");

    a_unsup_low: assert property (
        byte_valid_o && byte_addr_o == CAPS_B1 |-> byte_data_o[7:6] == UNSUP_FILL[1:0])
        else $error("unsupported field low bits wrong");

    a_unsup_edges: assert property (
        byte_valid_o && byte_addr_o == CAPS_B3 |-> byte_data_o[1:0] == UNSUP_FILL[11:10])
        else $error("unsupported field top bits wrong");

    a_reserved_zero: assert property (
        byte_valid_o && byte_addr_o == CAPS_B0 |-> byte_data_o[RSVD_LSB +: 2] == RSVD_FILL)
        else $error("reserved bits not zero");

    a_ascending_bytes: assert property (
        take_pull ##1 take_pull |=> byte_valid_o && byte_addr_o == $past(byte_addr_o) + ADDR_W'(1))
        else $error("stream address not ascending");

    a_pull_answer: assert property (
        take_pull |=> byte_valid_o && byte_addr_o == $past(pointer))
        else $error("pull not answered next cycle");

    a_vol_mid_byte: assert property (
        byte_valid_o && byte_addr_o == VOL_B2 |-> byte_data_o == VOL_OFFSET[23:16])
        else $error("volatile base third byte wrong");

    a_hit_window: assert property (
        byte_valid_o |-> byte_hit_o == in_table)
        else $error("hit flag does not match section window");

    a_miss_byte_zero: assert property (
        byte_valid_o && !byte_hit_o |-> byte_data_o == MISS_BYTE)
        else $error("byte outside section not the miss value");

    a_start_loads_ptr: assert property (
        start_i |=> in_stream && pointer == $past(start_addr_i))
        else $error("start did not load the pointer");

    a_stop_to_idle: assert property (
        in_stream && !start_i && stop_i |=> !in_stream && !pull_ready_o)
        else $error("stop did not end the session");

    a_refused_pull: assert property (
        start_i || stop_i |=> !byte_valid_o)
        else $error("byte returned beside start or stop");

    a_no_spurious_valid: assert property (
        !take_pull |=> !byte_valid_o)
        else $error("byte returned without a pull");

    a_pointer_holds: assert property (
        !take_pull && !start_i |=> pointer == $past(pointer))
        else $error("pointer moved without a pull");

    a_holds_between: assert property (
        !byte_valid_o && $past(rst_n_i) |->
            $stable(byte_data_o) && $stable(byte_addr_o) && $stable(byte_hit_o))
        else $error("returned byte changed between pulls");

    a_reset_quiet: assert property (
        !$past(rst_n_i) |->
            !byte_valid_o && !in_stream && byte_data_o == '0 && byte_addr_o == '0 && !byte_hit_o)
        else $error("outputs not cleared after reset");

    // every section byte in its place
    genvar b;
    generate
        for (b = 0; b < TABLE_BYTES; b++)
        begin : g_ref
            localparam logic [ADDR_W-1:0] B_ADDR = TABLE_BASE + ADDR_W'(b);

            a_table_byte: assert property (
                byte_valid_o && byte_addr_o == B_ADDR |->
                    byte_hit_o && byte_data_o == ref_dw[b / DW_BYTES][8 * (b % DW_BYTES) +: 8])
                else $error("table byte out of place");
        end
    endgenerate

    c_full_table: cover property (run_full);
    c_stop_pull: cover property (in_stream && stop_i && pull_i);
    c_caps_word: cover property (
        byte_valid_o && byte_addr_o == CAPS_B0 ##1 byte_valid_o [*3]);
    c_restart: cover property (in_stream && start_i);
    c_miss_read: cover property (byte_valid_o && !byte_hit_o);

endmodule // regmap_table_reader

// ==== dv/table_host_model.sv ====
// Purpose: host-side driver of the table read session
// Assumes: requests change 1 ns after the rising edge
// Notes:   no dummy phase at this port, bytes answer one cycle after a pull
`timescale 1ns/1ps
module table_host_model
    import regmap_table_pkg::*;
(
    // clock
    input  wire logic              clock_i,
    // session requests
    output logic                   start_o,
    output logic [ADDR_W-1:0]      start_addr_o,
    output logic                   stop_o,
    output logic                   pull_o
);
    initial
    begin
        start_o      = 1'b0;
        start_addr_o = '0;
        stop_o       = 1'b0;
        pull_o       = 1'b0;
    end

    // one request cycle: start, three-byte address, pull, stop
    task automatic drive(input logic s, input logic [ADDR_W-1:0] a, input logic p, input logic t);
        @(posedge clock_i);
        #1;
        start_o      = s;
        start_addr_o = a;
        pull_o       = p;
        stop_o       = t;
    endtask
endmodule // table_host_model

// ==== dv/regmap_table_reader_tb_top.sv ====
// Purpose: self-checking bench of the table reader
// Assumes: host model drives requests, bench drives reset
// Notes:   reference byte table built from the field codes
`timescale 1ns/1ps
module regmap_table_reader_tb_top;
    import regmap_table_pkg::*;

    bit                clock_i;
    logic              rst_n_i;
    logic              start_i;
    logic              stop_i;
    logic              pull_i;
    logic [ADDR_W-1:0] start_addr_i;
    logic              pull_ready_o;
    logic              byte_valid_o;
    logic              byte_hit_o;
    logic [7:0]        byte_data_o;
    logic [ADDR_W-1:0] byte_addr_o;
    logic [ADDR_W-1:0] ptr;
    logic [ADDR_W-1:0] exp_a;
    logic [31:0]       dwv [3];
    logic [31:0]       got_dw [3];
    bit                sess;
    bit                exp_v;
    int                fail_count;
    int                checks_done;
    int                seed;
    int                idx;

    regmap_table_reader regmap_table_reader_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i), .start_addr_i(start_addr_i),
        .stop_i(stop_i), .pull_i(pull_i), .pull_ready_o(pull_ready_o), .byte_valid_o(byte_valid_o),
        .byte_data_o(byte_data_o), .byte_hit_o(byte_hit_o), .byte_addr_o(byte_addr_o));

    table_host_model table_host_model_i (
        .clock_i(clock_i), .start_o(start_i), .start_addr_o(start_addr_i), .stop_o(stop_i), .pull_o(pull_i));

    task automatic chk_flag(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // reference byte, least significant byte first
    function automatic logic [7:0] exp_byte(input logic [ADDR_W-1:0] a);
        int i;
        i = int'(a) - 32'h16C;
        if (i < 0 || i > 11)
            return 8'h00;
        return 8'(dwv[i / 4] >> (8 * (i % 4)));
    endfunction

    // reference session model
    always @(posedge clock_i)
    begin
        exp_v = 1'b0;
        if (!rst_n_i)
            sess = 1'b0;
        else if (start_i)
        begin
            sess = 1'b1;
            ptr  = start_addr_i;
        end
        else if (stop_i)
            sess = 1'b0;
        else if (sess && pull_i)
        begin
            exp_v = 1'b1;
            exp_a = ptr;
            ptr   = ptr + 24'h000001;
        end
    end

    always @(negedge clock_i)
    begin
        chk_flag("byte_valid", exp_v, byte_valid_o);
        if (rst_n_i)
            chk_flag("pull_ready", sess && !start_i && !stop_i, pull_ready_o);
        if (exp_v)
        begin
            chk_word("byte_addr", 32'(exp_a), 32'(byte_addr_o));
            chk_word("byte_data", 32'(exp_byte(exp_a)), 32'(byte_data_o));
            chk_flag("byte_hit", exp_a >= 24'h00016C && exp_a <= 24'h000177, byte_hit_o);
            idx = int'(exp_a) - 32'h16C;
            if (idx >= 0 && idx < 12)
                got_dw[idx / 4][8 * (idx % 4) +: 8] = byte_data_o;
        end
    end

    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    initial
    begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        $display("Error watchdog expected finish seen timeout");
        end_of_test();
    end

    initial
    begin
        seed    = 36950;
        rst_n_i = 1'b0;
        sess    = 1'b0;
        exp_v   = 1'b0;
        got_dw  = '{default: 'x};
        dwv[0]  = 32'h0080_0000;
        dwv[1]  = 32'h0000_0000;
        dwv[2]  = {1'b1, 1'b1, 2'h2, 2'h2, 12'hFFF, 4'h3, 4'h3, 2'h0, 4'h0};
        repeat (2) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        // pulls outside a session, then full read past the section end
        repeat (2) table_host_model_i.drive(1'b0, '0, 1'b1, 1'b0);
        table_host_model_i.drive(1'b1, 24'h00016C, 1'b0, 1'b0);
        repeat (13) table_host_model_i.drive(1'b0, '0, 1'b1, 1'b0);
        table_host_model_i.drive(1'b0, '0, 1'b1, 1'b1);
        table_host_model_i.drive(1'b0, '0, 1'b1, 1'b0);
        repeat (2) table_host_model_i.drive(1'b0, '0, 1'b0, 1'b0);
        chk_word("vol_base", 32'h0080_0000, got_dw[0]);
        chk_word("nvol_base", 32'h0000_0000, got_dw[1]);
        chk_flag("gen_read", 1'b1, got_dw[2][31]);
        chk_flag("gen_write", 1'b1, got_dw[2][30]);
        chk_word("addr_bytes", 32'h2, 32'(got_dw[2][29:28]));
        chk_word("dummy_1b", 32'h2, 32'(got_dw[2][27:26]));
        chk_word("unsupported", 32'hFFF, 32'(got_dw[2][25:14]));
        chk_word("dummy_8s", 32'h3, 32'(got_dw[2][13:10]));
        chk_word("dummy_8d", 32'h3, 32'(got_dw[2][9:6]));
        chk_word("reserved", 32'h0, 32'(got_dw[2][5:4]));
        chk_word("dummy_1s", 32'h0, 32'(got_dw[2][3:0]));
        // start beats pull, restart, reset in mid-session
        table_host_model_i.drive(1'b1, 24'h000170, 1'b1, 1'b0);
        table_host_model_i.drive(1'b1, 24'h000174, 1'b0, 1'b0);
        repeat (4) table_host_model_i.drive(1'b0, '0, 1'b1, 1'b0);
        rst_n_i = 1'b0;
        table_host_model_i.drive(1'b0, '0, 1'b1, 1'b0);
        rst_n_i = 1'b1;
        repeat (2) table_host_model_i.drive(1'b0, '0, 1'b1, 1'b0);
        // random sessions around the section
        repeat (400)
            table_host_model_i.drive(($random(seed) % 8) == 0, 24'(32'h160 + ($random(seed) & 31)),
                                     1'($random(seed)), ($random(seed) % 16) == 0);
        repeat (3) table_host_model_i.drive(1'b0, '0, 1'b0, 1'b0);
        end_of_test();
    end
endmodule // regmap_table_reader_tb_top
